// ==== cxs_logic_unit.sv ====
// cxs_logic_unit: exclusive-or and increment datapath with flag results.
// assumes the sequencer picks the operands and decides when results are stored.
`timescale 1ns/100ps
module cxs_logic_unit (
	input wire logic [7:0] acc, // accumulator, or byte to increment
	input wire logic [7:0] operand, // selected xor operand
	input wire logic inc, // high selects increment of acc
	output logic [7:0] result,
	output logic [7:0] flags
);

	// ----------------------------------------------------------------
	// result and flags
	// ----------------------------------------------------------------
	// flags are only meaningful for the xor case
	always_comb
	begin
		if (inc)
			result = acc + 8'h01;
		else
			result = acc ^ operand;
		flags = 8'h00; // half carry, add/subtract and carry stay clear
		flags[cxs_pkg::FLAG_S] = result[7];
		flags[cxs_pkg::FLAG_Z] = (result == 8'h00);
		flags[cxs_pkg::FLAG_PV] = ~(^result);
	end

endmodule

// ==== cxs_mem_model.sv ====
// cxs_mem_model: memory space in front of the sequencer; port writes are not stored.
// assumes reads answer in the same cycle; slow adds one wait cycle per read.
`timescale 1ns/100ps
module cxs_mem_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic slow, // one wait cycle per read
	input wire logic [15:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] wdata,
	output logic wait_request,
	output logic [7:0] data_in
);
	logic [7:0] mem [0:65535]; // whole space, nops at start
	logic waited_r; // current read already waited
	logic [7:0] last_r; // last byte handed out
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	// stall each read once in slow mode
	assign wait_request = slow && rd && !waited_r;
	// invalid data while stalled or released
	assign data_in = (rd && !wait_request) ? mem[addr] : ~last_r;
	// wait bookkeeping and write port
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			waited_r <= 1'b0;
			last_r <= 8'h00;
		end
		else
		begin
			waited_r <= wait_request;
			if (rd && !wait_request)
				last_r <= mem[addr];
			if (wr)
				mem[addr] <= wdata;
		end
	end
endmodule

// ==== cxs_pkg.sv ====
// cxs_pkg: constants, encodings and state types shared by the sequencer and its logic unit.
// assumes one 250 MHz clock; nothing here holds logic.
package cxs_pkg;

	// ----------------------------------------------------------------
	// opcodes and prefixes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_NOP = 8'h00; // no operation
	localparam logic [7:0] OPC_XOR_IMM = 8'hee; // xor with immediate byte
	localparam logic [7:0] OPC_XOR_MEM = 8'hae; // xor with memory at pointer pair or index+d
	localparam logic [4:0] OPC_XOR_REG_HI = 5'h15; // upper five bits of the register xor form
	localparam logic [7:0] OPC_INC_MEM = 8'h34; // increment memory at pointer pair
	localparam logic [7:0] OPC_LD_IDX = 8'h21; // load index register with 16-bit immediate
	localparam logic [1:0] OPC_LD_IMM_HI = 2'h0; // top bits of load register with immediate
	localparam logic [2:0] OPC_LD_IMM_LO = 3'h6; // low bits of load register with immediate
	localparam logic [1:0] OPC_OUT_HI = 2'h1; // top bits of output register to port
	localparam logic [2:0] OPC_OUT_LO = 3'h1; // low bits of output register to port
	localparam logic [7:0] PFX_CODE_X = 8'hdd; // index x prefix
	localparam logic [7:0] PFX_CODE_Y = 8'hfd; // index y prefix
	localparam logic [7:0] PFX_CODE_E = 8'hed; // extended prefix

	// ----------------------------------------------------------------
	// register file layout
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_B = 3'h0; // counter pair high
	localparam logic [2:0] REG_C = 3'h1; // counter pair low
	localparam logic [2:0] REG_H = 3'h4; // pointer pair high
	localparam logic [2:0] REG_L = 3'h5; // pointer pair low
	localparam logic [2:0] REG_NONE = 3'h6; // not a register; slot holds the flags
	localparam logic [2:0] REG_F = 3'h6; // flag register slot
	localparam logic [2:0] REG_A = 3'h7; // accumulator

	// ----------------------------------------------------------------
	// flag bit positions
	// ----------------------------------------------------------------
	localparam int FLAG_S = 7; // sign
	localparam int FLAG_Z = 6; // zero
	localparam int FLAG_H = 4; // half carry
	localparam int FLAG_PV = 2; // parity / overflow
	localparam int FLAG_N = 1; // add / subtract
	localparam int FLAG_C = 0; // carry

	// ----------------------------------------------------------------
	// reset values and action cycle counts
	// ----------------------------------------------------------------
	localparam logic [15:0] RESET_PC = 16'h0000; // first fetch address
	localparam logic [2:0] CNT_NOP = 3'h1;
	localparam logic [2:0] CNT_XOR_REG = 3'h2;
	localparam logic [2:0] CNT_XOR_IMM = 3'h3;
	localparam logic [2:0] CNT_XOR_HL = 3'h3;
	localparam logic [2:0] CNT_XOR_IDX = 3'h4;
	localparam logic [2:0] CNT_INC_HL = 3'h5;
	localparam logic [2:0] CNT_OUT_C = 3'h2;
	localparam logic [2:0] CNT_LD_IMM = 3'h3;
	localparam logic [2:0] CNT_LD_IDX = 3'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_FETCH, ST_DECODE, ST_ACTION} cxs_state_type;
	typedef enum logic [1:0] {PFX_NONE, PFX_X, PFX_Y, PFX_E} cxs_pfx_type;
	typedef enum logic [3:0] {IN_NOP, IN_XOR_REG, IN_XOR_IMM, IN_XOR_HL, IN_XOR_IDX, IN_INC_HL,
		IN_OUT_C, IN_LD_IMM, IN_LD_IDX} cxs_instr_type;
	typedef enum logic [3:0] {ACT_NONE, ACT_RD_PC_TMP, ACT_RD_PC_DISP, ACT_RD_PC_IDXL, ACT_RD_PC_IDXH,
		ACT_RD_HL_TMP, ACT_RD_IDX_TMP, ACT_XOR_TMP, ACT_XOR_REG, ACT_INC_TMP, ACT_WR_HL, ACT_OUT,
		ACT_LD_REG} cxs_op_type;

	// whole state of the sequencer
	typedef struct packed {
		cxs_state_type state;
		cxs_pfx_type pfx;
		cxs_instr_type instr;
		cxs_op_type op;
		logic [7:0] ir;
		logic [2:0] cyc;
		logic [2:0] cnt;
		logic [15:0] pc;
		logic [15:0] idx_x;
		logic [15:0] idx_y;
		logic [7:0] tmp;
		logic [7:0] disp;
		logic [7:0][7:0] regs;
		logic [15:0] addr;
		logic [7:0] dout;
	} cxs_core_type;

	localparam cxs_core_type CORE_RESET = '0; // fetch state, pc at RESET_PC, all registers zero

endpackage

// ==== cxs_seq_asserts.sv ====
// cxs_seq_asserts: timing and strobe checks on the sequencer's ports.
// assumes one clock; bound to cxs_sequencer below.
`timescale 1ns/100ps
module cxs_seq_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic reset_req,
	input wire logic wait_request,
	input wire logic [7:0] data_in,
	input wire logic [15:0] addr,
	input wire logic [7:0] data_out_bus,
	input wire logic fetch_cycle_indicator,
	input wire logic mem_read_strobe,
	input wire logic mem_write_strobe,
	input wire logic io_write_strobe,
	input wire logic [7:0] acc_out,
	input wire logic [7:0] flags_out
);
	// ----------------------------------------------------------------
	// defaults and helpers
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn || reset_req);
	wire logic taken = fetch_cycle_indicator && !wait_request; // opcode accepted at this edge
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_reset_quiet: assert property (disable iff (!rstn) reset_req |-> !(fetch_cycle_indicator ||
		mem_read_strobe || mem_write_strobe || io_write_strobe) ##1 acc_out == 8'h00 && flags_out == 8'h00)
		else $error("strobes or state live during reset");
	chk_first_fetch: assert property (disable iff (!rstn) $fell(reset_req) |->
		fetch_cycle_indicator && mem_read_strobe && addr == 16'h0000) else $error("first fetch not at zero");
	chk_fetch_read: assert property (fetch_cycle_indicator |-> mem_read_strobe && !io_write_strobe)
		else $error("fetch without read strobe");
	chk_wait_hold: assert property (fetch_cycle_indicator && wait_request |=>
		fetch_cycle_indicator && $stable(addr)) else $error("fetch moved on while waiting");
	chk_decode_gap: assert property (taken |=> !fetch_cycle_indicator && !mem_read_strobe)
		else $error("no decode cycle after fetch");
	chk_nop_cycles: assert property (taken && data_in == cxs_pkg::OPC_NOP |=> !fetch_cycle_indicator
		##1 !fetch_cycle_indicator ##1 fetch_cycle_indicator) else $error("nop length wrong");
	chk_xor_self: assert property (taken && data_in == 8'haf |-> ##4 fetch_cycle_indicator
		&& acc_out == 8'h00 && flags_out[cxs_pkg::FLAG_Z]) else $error("xor a,a did not clear");
	chk_rmw_write: assert property (mem_write_strobe |-> $past(mem_read_strobe, 3)
		&& !$past(fetch_cycle_indicator, 3) && $past(addr, 3) == addr && data_out_bus == $past(data_in, 3) + 8'h01)
		else $error("write back does not match read");
	chk_port_write: assert property (io_write_strobe |-> $past(taken, 3)
		&& ($past(data_in, 3) & 8'hc7) == 8'h41 && !mem_write_strobe ##1 fetch_cycle_indicator)
		else $error("port write out of place");
	// main scenarios reached
	cov_wr: cover property (mem_write_strobe);
	cov_io: cover property (io_write_strobe);
	cov_wait: cover property (fetch_cycle_indicator && wait_request);
	cov_rst: cover property (disable iff (!rstn) $fell(reset_req));
endmodule

bind cxs_sequencer cxs_seq_asserts i_chk (.clk(clk), .rstn(rstn), .reset_req(reset_req),
	.wait_request(wait_request), .data_in(data_in), .addr(addr), .data_out_bus(data_out_bus),
	.fetch_cycle_indicator(fetch_cycle_indicator), .mem_read_strobe(mem_read_strobe),
	.mem_write_strobe(mem_write_strobe), .io_write_strobe(io_write_strobe), .acc_out(acc_out),
	.flags_out(flags_out));

// ==== cxs_sequencer.sv ====
// cxs_sequencer: fetch, decode and action sequencing of an 8-bit core with the xor family,
// increment of memory, load immediate, index load and register output to port.
// assumes memory and i/o share the address bus and answer on the same clock; only memory reads use wait_request.
`timescale 1ns/100ps

module cxs_sequencer (
	input wire logic clk,
	input wire logic rstn, // asynchronous power-on reset
	input wire logic reset_req, // synchronous reset, active high
	input wire logic wait_request, // memory not ready, active high
	input wire logic [7:0] data_in, // read data from memory
	output logic [15:0] addr, // address bus
	output logic [7:0] data_out_bus, // write data for memory and i/o
	output logic fetch_cycle_indicator, // high during opcode fetch
	output logic mem_read_strobe,
	output logic mem_write_strobe,
	output logic io_write_strobe,
	output logic [7:0] acc_out, // accumulator contents
	output logic [7:0] flags_out // flag register contents
);

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	// classify the opcode held in the instruction register
	function automatic cxs_pkg::cxs_instr_type classify(input logic [7:0] ir, input cxs_pkg::cxs_pfx_type pfx);
		classify = cxs_pkg::IN_NOP; // unknown codes behave as no operation
		if (pfx == cxs_pkg::PFX_E)
		begin
			if (ir[7:6] == cxs_pkg::OPC_OUT_HI && ir[2:0] == cxs_pkg::OPC_OUT_LO && ir[5:3] != cxs_pkg::REG_NONE)
				classify = cxs_pkg::IN_OUT_C;
		end
		else if (pfx != cxs_pkg::PFX_NONE)
		begin
			if (ir == cxs_pkg::OPC_XOR_MEM)
				classify = cxs_pkg::IN_XOR_IDX;
			else if (ir == cxs_pkg::OPC_LD_IDX)
				classify = cxs_pkg::IN_LD_IDX;
		end
		else if (ir == cxs_pkg::OPC_XOR_IMM)
			classify = cxs_pkg::IN_XOR_IMM;
		else if (ir == cxs_pkg::OPC_XOR_MEM)
			classify = cxs_pkg::IN_XOR_HL;
		else if (ir[7:3] == cxs_pkg::OPC_XOR_REG_HI)
			classify = cxs_pkg::IN_XOR_REG;
		else if (ir == cxs_pkg::OPC_INC_MEM)
			classify = cxs_pkg::IN_INC_HL;
		else if (ir[7:6] == cxs_pkg::OPC_LD_IMM_HI && ir[2:0] == cxs_pkg::OPC_LD_IMM_LO && ir[5:3] != cxs_pkg::REG_NONE)
			classify = cxs_pkg::IN_LD_IMM;
	endfunction

	// number of action cycles of an instruction
	function automatic logic [2:0] count_of(input cxs_pkg::cxs_instr_type instr);
		case (instr)
			cxs_pkg::IN_XOR_REG: count_of = cxs_pkg::CNT_XOR_REG;
			cxs_pkg::IN_XOR_IMM: count_of = cxs_pkg::CNT_XOR_IMM;
			cxs_pkg::IN_XOR_HL: count_of = cxs_pkg::CNT_XOR_HL;
			cxs_pkg::IN_XOR_IDX: count_of = cxs_pkg::CNT_XOR_IDX;
			cxs_pkg::IN_INC_HL: count_of = cxs_pkg::CNT_INC_HL;
			cxs_pkg::IN_OUT_C: count_of = cxs_pkg::CNT_OUT_C;
			cxs_pkg::IN_LD_IMM: count_of = cxs_pkg::CNT_LD_IMM;
			cxs_pkg::IN_LD_IDX: count_of = cxs_pkg::CNT_LD_IDX;
			default: count_of = cxs_pkg::CNT_NOP;
		endcase
	endfunction

	// control for one action cycle; cycle 1 is idle for every instruction
	function automatic cxs_pkg::cxs_op_type step_of(input cxs_pkg::cxs_instr_type instr, input logic [2:0] cyc);
		step_of = cxs_pkg::ACT_NONE;
		case (instr)
			cxs_pkg::IN_XOR_REG:
				if (cyc == 3'h2) step_of = cxs_pkg::ACT_XOR_REG;
			cxs_pkg::IN_XOR_IMM:
				if (cyc == 3'h2) step_of = cxs_pkg::ACT_RD_PC_TMP;
				else if (cyc == 3'h3) step_of = cxs_pkg::ACT_XOR_TMP;
			cxs_pkg::IN_XOR_HL:
				if (cyc == 3'h2) step_of = cxs_pkg::ACT_RD_HL_TMP;
				else if (cyc == 3'h3) step_of = cxs_pkg::ACT_XOR_TMP;
			cxs_pkg::IN_XOR_IDX:
				if (cyc == 3'h2) step_of = cxs_pkg::ACT_RD_PC_DISP;
				else if (cyc == 3'h3) step_of = cxs_pkg::ACT_RD_IDX_TMP;
				else if (cyc == 3'h4) step_of = cxs_pkg::ACT_XOR_TMP;
			cxs_pkg::IN_INC_HL:
				if (cyc == 3'h2) step_of = cxs_pkg::ACT_RD_HL_TMP;
				else if (cyc == 3'h3) step_of = cxs_pkg::ACT_INC_TMP;
				else if (cyc == 3'h5) step_of = cxs_pkg::ACT_WR_HL;
			cxs_pkg::IN_OUT_C:
				if (cyc == 3'h2) step_of = cxs_pkg::ACT_OUT;
			cxs_pkg::IN_LD_IMM:
				if (cyc == 3'h2) step_of = cxs_pkg::ACT_RD_PC_TMP;
				else if (cyc == 3'h3) step_of = cxs_pkg::ACT_LD_REG;
			cxs_pkg::IN_LD_IDX:
				if (cyc == 3'h2) step_of = cxs_pkg::ACT_RD_PC_IDXL;
				else if (cyc == 3'h3) step_of = cxs_pkg::ACT_RD_PC_IDXH;
			default: step_of = cxs_pkg::ACT_NONE;
		endcase
	endfunction

	// true for action cycles that read memory
	function automatic logic is_read(input cxs_pkg::cxs_op_type op);
		is_read = (op == cxs_pkg::ACT_RD_PC_TMP) || (op == cxs_pkg::ACT_RD_PC_DISP) ||
			(op == cxs_pkg::ACT_RD_PC_IDXL) || (op == cxs_pkg::ACT_RD_PC_IDXH) ||
			(op == cxs_pkg::ACT_RD_HL_TMP) || (op == cxs_pkg::ACT_RD_IDX_TMP);
	endfunction

	// ----------------------------------------------------------------
	// state and datapath signals
	// ----------------------------------------------------------------
	cxs_pkg::cxs_core_type core_r; // registered state
	cxs_pkg::cxs_core_type core_nxt; // next state
	logic [7:0] alu_acc; // first operand of the logic unit
	logic [7:0] alu_operand; // second operand of the logic unit
	logic alu_inc; // increment select
	logic [7:0] alu_result;
	logic [7:0] alu_flags;
	logic stall; // bus cycle held by wait_request

	// operand selection for the logic unit
	always_comb
	begin
		alu_inc = (core_r.op == cxs_pkg::ACT_INC_TMP);
		alu_acc = alu_inc ? core_r.tmp : core_r.regs[cxs_pkg::REG_A];
		if (core_r.op == cxs_pkg::ACT_XOR_REG)
			alu_operand = core_r.regs[core_r.ir[2:0]];
		else
			alu_operand = core_r.tmp;
	end

	cxs_logic_unit u_logic (
		.acc(alu_acc),
		.operand(alu_operand),
		.inc(alu_inc),
		.result(alu_result),
		.flags(alu_flags)
	);

	// ----------------------------------------------------------------
	// sequencer next state
	// ----------------------------------------------------------------
	always_comb
	begin
		core_nxt = core_r;
		stall = wait_request && ((core_r.state == cxs_pkg::ST_FETCH) || is_read(core_r.op));
		case (core_r.state)
			cxs_pkg::ST_FETCH:
			begin
				// opcode taken only when data is valid
				if (!stall)
				begin
					core_nxt.ir = data_in;
					core_nxt.pc = core_r.pc + 16'h0001;
					core_nxt.state = cxs_pkg::ST_DECODE;
				end
			end
			cxs_pkg::ST_DECODE:
			begin
				// a prefix fetches the real opcode next
				if (core_r.pfx == cxs_pkg::PFX_NONE && core_r.ir == cxs_pkg::PFX_CODE_X)
				begin
					core_nxt.pfx = cxs_pkg::PFX_X;
					core_nxt.state = cxs_pkg::ST_FETCH;
				end
				else if (core_r.pfx == cxs_pkg::PFX_NONE && core_r.ir == cxs_pkg::PFX_CODE_Y)
				begin
					core_nxt.pfx = cxs_pkg::PFX_Y;
					core_nxt.state = cxs_pkg::ST_FETCH;
				end
				else if (core_r.pfx == cxs_pkg::PFX_NONE && core_r.ir == cxs_pkg::PFX_CODE_E)
				begin
					core_nxt.pfx = cxs_pkg::PFX_E;
					core_nxt.state = cxs_pkg::ST_FETCH;
				end
				else
				begin
					// opcode fixes the cycle count
					core_nxt.instr = classify(core_r.ir, core_r.pfx);
					core_nxt.cnt = count_of(core_nxt.instr);
					core_nxt.cyc = 3'h1;
					core_nxt.op = step_of(core_nxt.instr, 3'h1);
					core_nxt.state = cxs_pkg::ST_ACTION;
				end
			end
			default:
			begin
				// action cycle: carry out the current control, then advance
				if (!stall)
				begin
					case (core_r.op)
						cxs_pkg::ACT_RD_PC_TMP:
						begin
							core_nxt.tmp = data_in;
							core_nxt.pc = core_r.pc + 16'h0001;
						end
						cxs_pkg::ACT_RD_PC_DISP:
						begin
							core_nxt.disp = data_in;
							core_nxt.pc = core_r.pc + 16'h0001;
						end
						cxs_pkg::ACT_RD_PC_IDXL:
						begin
							if (core_r.pfx == cxs_pkg::PFX_Y)
								core_nxt.idx_y[7:0] = data_in;
							else
								core_nxt.idx_x[7:0] = data_in;
							core_nxt.pc = core_r.pc + 16'h0001;
						end
						cxs_pkg::ACT_RD_PC_IDXH:
						begin
							if (core_r.pfx == cxs_pkg::PFX_Y)
								core_nxt.idx_y[15:8] = data_in;
							else
								core_nxt.idx_x[15:8] = data_in;
							core_nxt.pc = core_r.pc + 16'h0001;
						end
						cxs_pkg::ACT_RD_HL_TMP, cxs_pkg::ACT_RD_IDX_TMP:
							core_nxt.tmp = data_in;
						cxs_pkg::ACT_XOR_TMP, cxs_pkg::ACT_XOR_REG:
						begin
							core_nxt.regs[cxs_pkg::REG_A] = alu_result;
							core_nxt.regs[cxs_pkg::REG_F] = alu_flags;
						end
						cxs_pkg::ACT_INC_TMP:
							core_nxt.tmp = alu_result;
						cxs_pkg::ACT_LD_REG:
							core_nxt.regs[core_r.ir[5:3]] = core_r.tmp;
						default:
							core_nxt.tmp = core_r.tmp; // no datapath work this cycle
					endcase
					if (core_r.cyc == core_r.cnt)
					begin
						// last action cycle goes straight to the next fetch
						core_nxt.state = cxs_pkg::ST_FETCH;
						core_nxt.pfx = cxs_pkg::PFX_NONE;
						core_nxt.op = cxs_pkg::ACT_NONE;
					end
					else
					begin
						core_nxt.cyc = core_r.cyc + 3'h1;
						core_nxt.op = step_of(core_r.instr, core_nxt.cyc);
					end
				end
			end
		endcase
		// address and write data prepared for the coming cycle
		if (core_nxt.state == cxs_pkg::ST_FETCH)
			core_nxt.addr = core_nxt.pc;
		else if (core_nxt.state == cxs_pkg::ST_ACTION)
		begin
			case (core_nxt.op)
				cxs_pkg::ACT_RD_HL_TMP, cxs_pkg::ACT_WR_HL:
					core_nxt.addr = {core_nxt.regs[cxs_pkg::REG_H], core_nxt.regs[cxs_pkg::REG_L]};
				cxs_pkg::ACT_RD_IDX_TMP:
					// signed displacement added to the selected index
					core_nxt.addr = ((core_nxt.pfx == cxs_pkg::PFX_Y) ? core_nxt.idx_y : core_nxt.idx_x) +
						{{8{core_nxt.disp[7]}}, core_nxt.disp};
				cxs_pkg::ACT_OUT:
					core_nxt.addr = {core_nxt.regs[cxs_pkg::REG_B], core_nxt.regs[cxs_pkg::REG_C]};
				default:
					core_nxt.addr = core_nxt.pc;
			endcase
			if (core_nxt.op == cxs_pkg::ACT_WR_HL)
				core_nxt.dout = core_nxt.tmp;
			else if (core_nxt.op == cxs_pkg::ACT_OUT)
				core_nxt.dout = core_nxt.regs[core_nxt.ir[5:3]];
		end
		// synchronous reset wins over everything
		if (reset_req)
			core_nxt = cxs_pkg::CORE_RESET;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			core_r <= cxs_pkg::CORE_RESET;
		else
			core_r <= core_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// strobes decode the registered state; all quiet while reset_req is held
	always_comb
	begin
		fetch_cycle_indicator = !reset_req && (core_r.state == cxs_pkg::ST_FETCH);
		mem_read_strobe = !reset_req && (fetch_cycle_indicator ||
			(core_r.state == cxs_pkg::ST_ACTION && is_read(core_r.op)));
		mem_write_strobe = !reset_req && core_r.state == cxs_pkg::ST_ACTION &&
			core_r.op == cxs_pkg::ACT_WR_HL;
		io_write_strobe = !reset_req && core_r.state == cxs_pkg::ST_ACTION &&
			core_r.op == cxs_pkg::ACT_OUT;
	end

	assign addr = core_r.addr;
	assign data_out_bus = core_r.dout;
	assign acc_out = core_r.regs[cxs_pkg::REG_A];
	assign flags_out = core_r.regs[cxs_pkg::REG_F];

endmodule

// ==== testbench.sv ====
// testbench: runs xor, read-modify-write and port programs through the sequencer.
// assumes cxs_pkg, cxs_sequencer, the memory model and the checker are compiled first.
`timescale 1ns/100ps
module testbench;
	logic clk, rstn, reset_req, slow, wait_request, ind, rd, wr, io;
	logic [7:0] data_in, dout, acc, flg;
	logic [15:0] addr;
	int err_count = 0;
	int checks = 0;
	int pw; // program write pointer
	cxs_sequencer i_dut (.clk(clk), .rstn(rstn), .reset_req(reset_req), .wait_request(wait_request),
		.data_in(data_in), .addr(addr), .data_out_bus(dout), .fetch_cycle_indicator(ind),
		.mem_read_strobe(rd), .mem_write_strobe(wr), .io_write_strobe(io), .acc_out(acc), .flags_out(flg));
	cxs_mem_model i_mem (.clk(clk), .rstn(rstn), .slow(slow), .addr(addr), .rd(rd), .wr(wr),
		.wdata(dout), .wait_request(wait_request), .data_in(data_in));
	// 250 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// compare and count
	task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic put(input logic [7:0] b);
		i_mem.mem[pw] = b;
		pw++;
	endtask
	// find n accepted fetches, stepping past each if asked
	task automatic to_fetch(input int n, input bit step);
		int k;
		repeat (n)
		begin
			for (k = 0; k < 40 && !(ind === 1'b1 && wait_request === 1'b0); k++)
				@(negedge clk);
			// a fetch that never comes is a hang and counts as a mismatch
			if (k == 40)
				cmp("fetch reached", 1'b0, 1'b1);
			if (step)
				@(negedge clk);
		end
	endtask
	// synchronous reset for two cycles, then release into the first fetch
	task automatic boot(input logic s);
		@(negedge clk);
		reset_req = 1'b1;
		slow = s;
		repeat (2) @(negedge clk);
		cmp("reset strobes", {ind, rd, wr, io}, 4'h0);
		cmp("reset state", {acc, flg}, 16'h0000);
		reset_req = 1'b0;
		#1;
		cmp("first fetch", {ind, rd, addr}, 18'h30000);
	endtask
	// result of one xor seen at the next fetch
	task automatic xchk(input int nf, input logic [7:0] e);
		to_fetch(nf, 1);
		to_fetch(1, 0);
		cmp("acc", acc, e);
		cmp("flags", flg & 8'hd7, {e[7], e == 8'h00, 3'h0, ~^e, 2'h0});
	endtask
	// every xor form, register codes included
	task automatic t_xor();
		logic [7:0] v [6] = '{8'h81, 8'h42, 8'h24, 8'h18, 8'h20, 8'h10};
		logic [7:0] t [17] = '{8'hee, 8'h7f, 8'hae, 8'hdd, 8'h21, 8'h00, 8'h30, 8'hdd, 8'hae, 8'hfe,
			8'hfd, 8'h21, 8'h80, 8'h40, 8'hfd, 8'hae, 8'h7f};
		logic [7:0] a;
		pw = 0;
		for (int r = 0; r < 6; r++)
		begin
			put({2'h0, 3'(r), 3'h6});
			put(v[r]);
		end
		put(8'h3e);
		put(8'h3c);
		for (int r = 0; r < 8; r++)
			if (r != 6)
				put({cxs_pkg::OPC_XOR_REG_HI, 3'(r)});
		foreach (t[i])
			put(t[i]);
		i_mem.mem[16'h2010] = 8'hff;
		i_mem.mem[16'h2ffe] = 8'h01;
		i_mem.mem[16'h40ff] = 8'h80;
		boot(1'b0);
		to_fetch(7, 1);
		a = 8'h3c;
		for (int r = 0; r < 8; r++)
			if (r != 6)
			begin
				a = a ^ ((r == 7) ? a : v[r]);
				xchk(1, a);
			end
		xchk(1, a ^ 8'h7f);
		xchk(1, 8'h80);
		to_fetch(2, 1);
		xchk(2, 8'h81);
		to_fetch(2, 1);
		xchk(2, 8'h01);
	endtask
	// increment memory then port write, every read stalled once
	task automatic t_rmw_io();
		logic [7:0] p [11] = '{8'h26, 8'h12, 8'h2e, 8'h34, 8'h34, 8'h06, 8'hab, 8'h0e, 8'hcd, 8'hed, 8'h41};
		int nr = 0;
		int nw = 0;
		int nio = 0;
		pw = 0;
		foreach (p[i])
			put(p[i]);
		i_mem.mem[16'h1234] = 8'hff;
		boot(1'b1);
		cmp("wait raised", {ind, wait_request}, 2'h3);
		@(negedge clk);
		cmp("stalled fetch", {ind, wait_request, addr}, 18'h20000);
		repeat (60)
		begin
			@(negedge clk);
			if (rd && !ind && addr == 16'h1234)
				nr++;
			if (wr)
			begin
				nw++;
				cmp("rmw write", {rd, addr, dout}, {1'b0, 16'h1234, 8'h00});
			end
			if (io)
			begin
				nio++;
				cmp("port write", {wr, addr, dout}, {1'b0, 16'habcd, 8'hab});
			end
		end
		cmp("cycle counts", {nr[7:0], nw[7:0], nio[7:0]}, 24'h020101);
		cmp("stored", i_mem.mem[16'h1234], 8'h00);
	endtask
	// main sequence
	initial
	begin
		rstn = 1'b0;
		reset_req = 1'b0;
		slow = 1'b0;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		t_xor();
		t_rmw_io();
		print_verdict();
	end
	// watchdog: both programs need under two hundred cycles, allow about 5000
	initial
	begin
		#20000;
		err_count++;
		print_verdict();
	end
endmodule
